// >>> shared/part_defs.svh
`ifndef PART_DEFS_SVH
`define PART_DEFS_SVH

// register byte addresses on the wishbone bus
`define ART_DUTY0_ADDR    8'h00
`define ART_DUTY1_ADDR    8'h04
`define ART_DUTY2_ADDR    8'h08
`define ART_DUTY3_ADDR    8'h0c
`define ART_PWMCTL_ADDR   8'h10
`define ART_CSR_ADDR      8'h14
`define ART_CAR_ADDR      8'h18
`define ART_ARR_ADDR      8'h1c
// control/status and pwm control field positions
`define ART_CSR_CLOCK_SOURCE_SELECT      7
`define ART_CSR_CC_HI     6
`define ART_CSR_CC_LO     4
`define ART_CSR_TCE       3
`define ART_CSR_FORCE_RELOAD      2
`define ART_CSR_OIE       1
`define ART_CSR_OVF       0
`define ART_PWM_OE_LO     4
// reset value and the counter value that overflows
`define ART_RESET_BYTE    8'h00
`define ART_CNT_MAX       8'hff
`endif

// >>> shared/art_pkg.sv
package art_pkg;
   // one bus access at a time: idle or answering
   typedef enum logic [0:0]
   {
      ART_IDLE = 1'b0,
      ART_ACK  = 1'b1
   } art_bus_t;

   typedef logic [7:0] art_byte_t;

   typedef struct packed
   {
      art_bus_t        bus;
      art_byte_t [3:0] duty;
      art_byte_t [3:0] cmp;
      logic [3:0]      oe;
      logic [3:0]      pol;
      logic            clock_source_select;
      logic [2:0]      cc;
      logic            counter_enable;
      logic            overflow_irq_enable;
      logic            ovf;
      art_byte_t       arr;
      art_byte_t       cnt;
      logic [6:0]      pre;
      logic [3:0]      pwm_lvl;
      logic [3:0]      pwm_out;
      logic [3:0]      pwm_oe;
      logic            irq;
      art_byte_t       rdat;
      logic            ext_s1;
      logic            ext_s2;
      logic            ext_s3;
   } art_state_t;
endpackage

// >>> rtl/art_timer.sv
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "part_defs.svh"
module art_timer
(
   // clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        NRST_I,
   // wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   // board side
   input  wire logic        EXT_CLK_I,
   input  wire logic        HALT_I,
   output logic      [3:0]  PWM_O,
   output logic      [3:0]  PWM_OE_O,
   output logic             IRQ_O
);
   art_pkg::art_state_t st_reg;
   art_pkg::art_state_t st_next;

   logic       req;
   logic       wr;
   logic       rd;
   logic       frozen;
   logic       tick_in;
   logic       cnt_tick;
   logic       ovf_evt;
   logic       init_evt;
   logic [7:0] wbyte;
   logic [7:0] csr_rd;
   logic [6:0] pre_inc;
   logic [7:0] pre_mask;

   // byte lane 0 carries the eight-bit registers; upper lanes read as zero
   assign req   = CYC_I && STB_I && (st_reg.bus == art_pkg::ART_IDLE);
   assign wr    = req && WE_I && SEL_I[0];
   assign rd    = req && !WE_I;
   assign wbyte = DAT_I[7:0];
   // halted with the external clock still counting, but no register writes land
   assign frozen = HALT_I;
   assign csr_rd = {st_reg.clock_source_select, st_reg.cc, st_reg.counter_enable, 1'b0, st_reg.overflow_irq_enable, st_reg.ovf};

   // input tick: every cpu cycle, or a synchronised rising edge of the pin
   always_comb
   begin
      if (st_reg.clock_source_select)
      begin
         tick_in = st_reg.ext_s2 && !st_reg.ext_s3;
      end
      else
      begin
         tick_in = !HALT_I;  // cpu clock stops in halt
      end
   end

   // prescaler tap: bits below the selected tap all ones means next input tick wraps that tap
   assign pre_inc  = st_reg.pre + 7'h01;
   assign pre_mask = (8'h01 << st_reg.cc) - 8'h01;
   assign cnt_tick = st_reg.counter_enable && tick_in && ((st_reg.pre & pre_mask[6:0]) == pre_mask[6:0]);
   assign ovf_evt  = cnt_tick && (st_reg.cnt == `ART_CNT_MAX);
   assign init_evt = !frozen && wr && (((ADR_I == `ART_CSR_ADDR) && wbyte[`ART_CSR_FORCE_RELOAD])
                     || (ADR_I == `ART_CAR_ADDR));

   always_comb
   begin
      st_next = st_reg;
      // pin synchroniser; third stage only feeds the edge detector
      st_next.ext_s1 = EXT_CLK_I;
      st_next.ext_s2 = st_reg.ext_s1;
      st_next.ext_s3 = st_reg.ext_s2;

      // bus answer one cycle after the request, dropped the cycle after
      st_next.bus = req ? art_pkg::ART_ACK : art_pkg::ART_IDLE;
      if (rd)
      begin
         case (ADR_I)
            `ART_DUTY0_ADDR:  st_next.rdat = st_reg.duty[0];
            `ART_DUTY1_ADDR:  st_next.rdat = st_reg.duty[1];
            `ART_DUTY2_ADDR:  st_next.rdat = st_reg.duty[2];
            `ART_DUTY3_ADDR:  st_next.rdat = st_reg.duty[3];
            `ART_PWMCTL_ADDR: st_next.rdat = {st_reg.oe, st_reg.pol};
            `ART_CSR_ADDR:    st_next.rdat = csr_rd;
            `ART_CAR_ADDR:    st_next.rdat = st_reg.cnt;
            `ART_ARR_ADDR:    st_next.rdat = st_reg.arr;
            default:          st_next.rdat = `ART_RESET_BYTE;  // unmapped reads zero; no prescaler path
         endcase
      end

      // prescaler and counter advance; frozen when counter_enable is low
      if (st_reg.counter_enable && tick_in)
      begin
         st_next.pre = pre_inc;
      end
      if (cnt_tick)
      begin
         if (ovf_evt)
         begin
            st_next.cnt = st_reg.arr;
            st_next.cmp = st_reg.duty;
         end
         else
         begin
            st_next.cnt = st_reg.cnt + 8'h01;
         end
      end

      // reading the status clears the flag, but a same-cycle overflow still wins
      if (rd && (ADR_I == `ART_CSR_ADDR))
      begin
         st_next.ovf = 1'b0;
      end
      if (ovf_evt)
      begin
         st_next.ovf = 1'b1;
      end

      // register writes, blocked while halted
      if (wr && !frozen)
      begin
         case (ADR_I)
            `ART_DUTY0_ADDR:  st_next.duty[0] = wbyte;
            `ART_DUTY1_ADDR:  st_next.duty[1] = wbyte;
            `ART_DUTY2_ADDR:  st_next.duty[2] = wbyte;
            `ART_DUTY3_ADDR:  st_next.duty[3] = wbyte;
            `ART_PWMCTL_ADDR:
            begin
               st_next.oe  = wbyte[7:`ART_PWM_OE_LO];
               st_next.pol = wbyte[3:0];
            end
            `ART_CSR_ADDR:
            begin
               st_next.clock_source_select = wbyte[`ART_CSR_CLOCK_SOURCE_SELECT];
               st_next.cc   = wbyte[`ART_CSR_CC_HI:`ART_CSR_CC_LO];
               st_next.counter_enable  = wbyte[`ART_CSR_TCE];
               st_next.overflow_irq_enable  = wbyte[`ART_CSR_OIE];
               if (wbyte[`ART_CSR_FORCE_RELOAD])
               begin
                  st_next.cnt = st_reg.arr;
               end
            end
            `ART_CAR_ADDR:    st_next.cnt = wbyte;
            `ART_ARR_ADDR:    st_next.arr = wbyte;
            default:          st_next.arr = st_reg.arr;
         endcase
      end
      if (init_evt)
      begin
         st_next.pre = 7'h00;
      end

      // waveform level: active from overflow, restored once counter passes compare
      for (int i = 0; i < 4; i++)
      begin
         if (HALT_I)
         begin
            st_next.pwm_lvl[i] = st_reg.pwm_lvl[i];
         end
         else
         begin
            // equals high at or below compare, low above
            st_next.pwm_lvl[i] = (st_next.cnt <= st_next.cmp[i]);
         end
         // polarity acts immediately; 0%/100% at reload zero by inversion
         st_next.pwm_out[i] = st_next.pwm_lvl[i] ^ st_next.pol[i];
         st_next.pwm_oe[i]  = st_next.oe[i];
         if (!st_next.oe[i])
         begin
            st_next.pwm_out[i] = 1'b0;
         end
      end

      // level interrupt; compare above reload is left to software
      st_next.irq = st_next.ovf && st_next.overflow_irq_enable;
   end

   // single state register, synchronous active-low reset
   always_ff @(posedge MCLK_I)
   begin
      if (!NRST_I)
      begin
         st_reg     <= '0;
         st_reg.bus <= art_pkg::ART_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign DAT_O    = {24'h000000, st_reg.rdat};
   assign ACK_O    = (st_reg.bus == art_pkg::ART_ACK);
   assign PWM_O    = st_reg.pwm_out;
   assign PWM_OE_O = st_reg.pwm_oe;
   assign IRQ_O    = st_reg.irq;
endmodule

// >>> sim/art_timer_props.sv
`timescale 1ns/100ps
module art_timer_props
(
   // clock, reset and wishbone side
   input wire logic        MCLK_I, NRST_I, CYC_I, STB_I, WE_I,
   input wire logic [7:0]  ADR_I,
   input wire logic [3:0]  SEL_I,
   input wire logic [31:0] DAT_I, DAT_O,
   input wire logic        ACK_O,
   // board side
   input wire logic        EXT_CLK_I, HALT_I, IRQ_O,
   input wire logic [3:0]  PWM_O, PWM_OE_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);
   // bus handshake: one answer per request, one cycle later
   ack_latency_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
   ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack held");
   upper_zero_a: assert property (ACK_O |-> DAT_O[31:8] == 24'h0) else $error("upper read bits set");
   force_reads_zero_a: assert property (ACK_O && !WE_I && ADR_I == 8'h14 |-> !DAT_O[2])
      else $error("force bit read as one");
   unmapped_zero_a: assert property (ACK_O && !WE_I && ADR_I == 8'h20 |-> DAT_O == 32'h0)
      else $error("unmapped read not zero");
   // a disabled channel never drives a level onto its pin
   pwm_gate_a: assert property ((PWM_O & ~PWM_OE_O) == 4'h0) else $error("disabled pwm driven");
   halt_freeze_a: assert property ($past(HALT_I, 2) && $past(HALT_I) && HALT_I |-> $stable(PWM_O))
      else $error("pwm moved in halt");
   irq_status_a: assert property (ACK_O && !WE_I && ADR_I == 8'h14 && $past(IRQ_O) |-> DAT_O[1:0] == 2'b11)
      else $error("irq without flag and enable");
endmodule
bind art_timer art_timer_props i_props (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .CYC_I(CYC_I), .STB_I(STB_I),
   .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
   .EXT_CLK_I(EXT_CLK_I), .HALT_I(HALT_I), .IRQ_O(IRQ_O), .PWM_O(PWM_O), .PWM_OE_O(PWM_OE_O));

// >>> sim/test_pwm_auto_reload_timer.sv
`timescale 1ns/100ps
module test_pwm_auto_reload_timer;
   logic        MCLK_I = 0, NRST_I = 0, CYC_I = 0, STB_I = 0, WE_I = 0, EXT_CLK_I = 0, HALT_I = 0;
   logic [7:0]  ADR_I = 8'h00;
   logic [3:0]  SEL_I = 4'h0;
   logic [31:0] DAT_I = 32'h0;
   logic [31:0] DAT_O;
   logic        ACK_O, IRQ_O;
   logic [3:0]  PWM_O, PWM_OE_O;
   logic [7:0]  v;
   int          n_errors = 0, tests_run = 0, cyc_cnt = 0;
   art_timer i_dut (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
      .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .EXT_CLK_I(EXT_CLK_I),
      .HALT_I(HALT_I), .PWM_O(PWM_O), .PWM_OE_O(PWM_OE_O), .IRQ_O(IRQ_O));
   always #50 MCLK_I = ~MCLK_I;
   // a hung handshake ends the run through the same report
   always @(posedge MCLK_I)
   begin
      cyc_cnt++;
      if (cyc_cnt == 3000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin n_errors++; $display("[ERR] %s expected %h seen %h", nm, exp, seen); end
   endtask
   // classic single cycle; request held until ack is seen high at an edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge MCLK_I);
      CYC_I <= 1; STB_I <= 1; WE_I <= we; ADR_I <= a; SEL_I <= 4'h1; DAT_I <= {24'h0, d};
      do @(posedge MCLK_I); while (ACK_O !== 1'b1);
      q = DAT_O[7:0];
      CYC_I <= 0; STB_I <= 0; WE_I <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      check(nm, q, exp);
   endtask
   task automatic t_access();
      rdc("csr rst", 8'h14, 8'h00); rdc("car rst", 8'h18, 8'h00); rdc("arr rst", 8'h1c, 8'h00);
      rdc("unmapped", 8'h20, 8'h00);
      wr(8'h18, 8'h5a); repeat (10) @(posedge MCLK_I);
      rdc("car frozen", 8'h18, 8'h5a);
      wr(8'h1c, 8'hc3); wr(8'h14, 8'h04);
      rdc("force load", 8'h18, 8'hc3);
      rdc("force reads 0", 8'h14, 8'h00);
      $display("access test done");
   endtask
   task automatic t_overflow();
      logic p;
      // duty above the reload value so a waveform appears
      wr(8'h1c, 8'hf0); wr(8'h00, 8'hf8); wr(8'h10, 8'h10); wr(8'h18, 8'hfc); wr(8'h14, 8'h0a);
      for (int i = 0; i < 40 && IRQ_O !== 1'b1; i++) @(posedge MCLK_I);
      check("irq", IRQ_O, 1'b1);
      rdc("csr flag", 8'h14, 8'h0b);
      wr(8'h14, 8'h02);
      rdc("flag clear", 8'h14, 8'h02);
      check("irq low", IRQ_O, 1'b0);
      wb(1'b0, 8'h18, 8'h00, v);
      check("reload range", v >= 8'hf0, 1'b1);
      check("oe", PWM_OE_O, 4'h1);
      p = (v <= 8'hf8);
      check("pwm level", PWM_O[0], p);
      wr(8'h00, 8'h00); repeat (2) @(posedge MCLK_I);
      check("duty buffered", PWM_O[0], p);
      wr(8'h10, 8'h11); repeat (2) @(posedge MCLK_I);
      check("polarity", PWM_O[0], !p);
      $display("overflow test done");
   endtask
   task automatic t_clocks();
      wr(8'h18, 8'h00); wr(8'h14, 8'h38); repeat (80) @(posedge MCLK_I); wr(8'h14, 8'h30);
      wb(1'b0, 8'h18, 8'h00, v);
      check("divide by 8", v >= 8'd9 && v <= 8'd11, 1'b1);
      wr(8'h18, 8'h20); wr(8'h14, 8'h88);
      repeat (3)
      begin
         repeat (4) @(posedge MCLK_I); EXT_CLK_I <= 1;
         repeat (4) @(posedge MCLK_I); EXT_CLK_I <= 0;
      end
      repeat (4) @(posedge MCLK_I); wr(8'h14, 8'h80);
      rdc("ext events", 8'h18, 8'h23);
      @(posedge MCLK_I); HALT_I <= 1; wr(8'h1c, 8'h55); @(posedge MCLK_I); HALT_I <= 0;
      rdc("halt frozen", 8'h1c, 8'hf0);
      $display("clock test done");
   endtask
   initial
   begin
      repeat (16) @(posedge MCLK_I);
      NRST_I <= 1;
      t_access();
      t_overflow();
      t_clocks();
      tally_and_finish();
   end
endmodule
